// File: rtl/drive_prot_pkg.sv
// Purpose: shared constants and carrier types for the drive protection supervisor
// Assumes: 32-bit classic Wishbone register port, byte addresses
// Notes: speed inputs are scaled integers, see field comments

`default_nettype none

package drive_prot_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;     // modes and policies
   localparam logic [7:0] OFS_OVS_LVL = 8'h04;  // over-speed level, 0.1 %
   localparam logic [7:0] OFS_OVS_TIME = 8'h08; // over-speed time, 0.01 s
   localparam logic [7:0] OFS_DEV_HZ = 8'h0c;   // deviation band, 0.01 Hz
   localparam logic [7:0] OFS_DEV_RPM = 8'h10;  // deviation band, rpm
   localparam logic [7:0] OFS_DEV_TIME = 8'h14; // deviation time, 0.1 s
   localparam logic [7:0] OFS_TEMP_THR = 8'h18; // fan temperature, deg C
   localparam logic [7:0] OFS_DOUT_FN = 8'h1c;  // three 8-bit output codes
   localparam logic [7:0] OFS_STATUS = 8'h20;   // live state, read only
   localparam logic [7:0] OFS_IRQ_ST = 8'h24;   // sticky events, write 1 clears
   localparam logic [7:0] OFS_IRQ_MASK = 8'h28; // event enables
   localparam logic [7:0] OFS_TRIP_CLR = 8'h2c; // write 1 clears latched trips
   localparam logic [7:0] OFS_DIN_FN = 8'h30;   // eight 4-bit input codes

   // ----------------------------------------------------------------
   // control field positions
   // ----------------------------------------------------------------
   localparam int CTRL_M1_MODE = 0;    // 3 bits
   localparam int CTRL_M2_MODE = 3;    // 3 bits
   localparam int CTRL_DEV_EN = 6;
   localparam int CTRL_RPM_UNIT = 7;
   localparam int CTRL_FAN_POL = 8;    // 2 bits
   localparam int CTRL_MAIN_FMODE = 10;
   localparam int CTRL_AUX_FMODE = 11;
   localparam int CTRL_RESTART = 12;   // 2 bits
   localparam int CTRL_W = 14;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [13:0] RST_CTRL = 14'h1000;      // restart 1, all else 0
   localparam logic [15:0] RST_OVS_LVL = 16'h04b0;   // 120.0 %
   localparam logic [15:0] RST_OVS_TIME = 16'h0001;  // 0.01 s
   localparam logic [15:0] RST_DEV_HZ = 16'h07d0;    // 20.00 Hz
   localparam logic [15:0] RST_DEV_RPM = 16'h0258;   // 600 rpm
   localparam logic [15:0] RST_DEV_TIME = 16'h000a;  // 1.0 s
   localparam logic [7:0] RST_TEMP_THR = 8'h3c;      // plain default
   localparam logic [23:0] RST_DOUT_FN = 24'h000e18; // 24, 14, 0
   localparam logic [31:0] RST_DIN_FN = 32'h9cba5421; // 1,2,4,5,10,11,12,9

   // ----------------------------------------------------------------
   // codes and timing
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_SENSORLESS = 3'h3;
   localparam logic [2:0] MODE_VECTOR = 3'h4;
   localparam logic [1:0] FAN_DURING_RUN = 2'h0;
   localparam logic [1:0] FAN_ALWAYS = 2'h1;
   localparam logic [1:0] FAN_TEMP_CTRL = 2'h2;
   localparam logic [1:0] RESTART_NONE = 2'h0;
   localparam logic [1:0] RESTART_ACCEL = 2'h1;
   localparam logic [1:0] RESTART_SEARCH = 2'h2;
   localparam logic [7:0] DOUT_FAN_WARN = 8'h08;
   localparam logic [3:0] DIN_BLOCK = 4'h4;
   localparam int CLK_PERIOD_NS = 5;             // 200 MHz
   localparam int TICK_PERIOD_NS = 10_000_000;   // 10 ms time base
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [19:0] DEV_TICKS_PER_UNIT = 20'h0000a; // 0.1 s in ticks
   localparam int IRQ_W = 6;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic power_ok;        // input power present
      logic run_cmd;         // run command
      logic [7:0] heat_temp; // heat-sink temperature, deg C
      logic main_fan_err;
      logic aux_fan_err;
      logic [7:0] din;       // digital input terminals
   } drive_in_s;

   typedef struct packed {
      logic [15:0] speed_pct; // measured speed, 0.1 %
      logic [15:0] dev_hz;    // speed deviation magnitude, 0.01 Hz
      logic [15:0] dev_rpm;   // speed deviation magnitude, rpm
   } speed_in_s;

endpackage : drive_prot_pkg

`default_nettype wire

// File: rtl/drive_speed_fan_protection.sv
// Purpose: over-speed, speed-deviation and cooling-fan protection with restart control
// Assumes: inputs synchronous to core_clk; registers over classic Wishbone
// Notes: trips and events latch, hardware set wins over software clear
//
// Local design decisions: register access over Wishbone and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module drive_speed_fan_protection
#(
   parameter int TICK_CYC = drive_prot_pkg::TICK_CYCLES // shorten in simulation
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire drive_prot_pkg::wb_req_s wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire drive_prot_pkg::drive_in_s drv_in,
   input wire drive_prot_pkg::speed_in_s spd_in,
   output logic output_block,
   output logic fan_on,
   output logic [2:0] dout,
   output logic accel_restart,
   output logic speed_search,
   output logic irq
);
   import drive_prot_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [15:0] ovs_lvl;
      logic [15:0] ovs_time;
      logic [15:0] dev_hz;
      logic [15:0] dev_rpm;
      logic [15:0] dev_time;
      logic [7:0] temp_thr;
      logic [23:0] dout_fn;
      logic [31:0] din_fn;
      logic [IRQ_W-1:0] irq_st;
      logic [IRQ_W-1:0] irq_mask;
      logic [2:0] trip;       // over-speed, deviation, fan
      logic [31:0] tick_cnt;  // time-base divider
      logic tick;             // one-cycle 10 ms enable
      logic [15:0] ovs_cnt;
      logic [19:0] dev_cnt;
      logic blk_in;           // block input seen last cycle
      logic warn;             // fan warning level
      logic ack;
      logic [31:0] rdat;
      logic accel;
      logic search;
      logic fan;
      logic block;
      logic [2:0] dout;
   } state_s;

   state_s s_q; // registered state
   state_s s_d; // next state

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[i*8 +: 8] = wdat[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ----------------------------------------------------------------
   // combinational helpers
   // ----------------------------------------------------------------
   logic sup_en;       // supervision allowed in this control mode
   logic ovs_hit;      // speed above level now
   logic dev_hit;      // deviation beyond band now
   logic [19:0] dev_lim; // deviation time in ticks
   logic blk_now;      // any terminal coded as block input is on
   logic hot;          // heat sink at or above threshold
   logic [2:0] trip_set;
   logic [IRQ_W-1:0] ev;
   logic wr;
   logic rd_req;
   logic [31:0] wmrg;
   logic [31:0] status;

   // compare helpers, trip set vector and status word
   always_comb
   begin
      // only sensorless or vector control on motor 1, or sensorless on motor 2, is supervised
      // control mode gate
      sup_en = (s_q.ctrl[CTRL_M1_MODE +: 3] == MODE_SENSORLESS)
             || (s_q.ctrl[CTRL_M1_MODE +: 3] == MODE_VECTOR)
             || (s_q.ctrl[CTRL_M2_MODE +: 3] == MODE_SENSORLESS);
      ovs_hit = sup_en && (spd_in.speed_pct > s_q.ovs_lvl);
      if (s_q.ctrl[CTRL_RPM_UNIT])
      begin
         dev_hit = spd_in.dev_rpm > s_q.dev_rpm;
      end
      else
      begin
         dev_hit = spd_in.dev_hz > s_q.dev_hz;
      end
      dev_hit = dev_hit && sup_en && s_q.ctrl[CTRL_DEV_EN];
      dev_lim = 20'(s_q.dev_time * DEV_TICKS_PER_UNIT);
      blk_now = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         if (s_q.din_fn[i*4 +: 4] == DIN_BLOCK && drv_in.din[i])
         begin
            blk_now = 1'b1;
         end
      end
      hot = drv_in.heat_temp >= s_q.temp_thr;
      trip_set = 3'h0;
      trip_set[0] = s_q.tick && ovs_hit && (s_q.ovs_cnt + 16'h0001 >= s_q.ovs_time);
      trip_set[1] = s_q.tick && dev_hit && (s_q.dev_cnt + 20'h00001 >= dev_lim);
      trip_set[2] = (drv_in.main_fan_err && !s_q.ctrl[CTRL_MAIN_FMODE])
                 || (drv_in.aux_fan_err && !s_q.ctrl[CTRL_AUX_FMODE]);
      wr = wb_req.cyc && wb_req.stb && wb_req.we && !s_q.ack;
      rd_req = wb_req.cyc && wb_req.stb && !s_q.ack;
      status = {24'h0, s_q.block, s_q.fan, s_q.warn, s_q.blk_in, sup_en, s_q.trip};
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      wmrg = 32'h0;
      s_d = s_q;
      s_d.ack = rd_req;
      s_d.accel = 1'b0;
      s_d.search = 1'b0;

      // time base divider
      if (s_q.tick_cnt >= 32'(TICK_CYC - 1))
      begin
         s_d.tick_cnt = 32'h0;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.tick_cnt = s_q.tick_cnt + 32'h1;
         s_d.tick = 1'b0;
      end

      // over-speed persistence counter, cleared on any dip
      if (!ovs_hit)
      begin
         s_d.ovs_cnt = 16'h0;
      end
      else if (s_q.tick && s_q.ovs_cnt != 16'hffff)
      begin
         s_d.ovs_cnt = s_q.ovs_cnt + 16'h0001;
      end
      if (!dev_hit)
      begin
         s_d.dev_cnt = 20'h0;
      end
      else if (s_q.tick && s_q.dev_cnt != 20'hfffff)
      begin
         s_d.dev_cnt = s_q.dev_cnt + 20'h00001;
      end

      // warning mode keeps running, flags the fan
      s_d.warn = (drv_in.main_fan_err && s_q.ctrl[CTRL_MAIN_FMODE])
              || (drv_in.aux_fan_err && s_q.ctrl[CTRL_AUX_FMODE]);
      for (int i = 0; i < 3; i++)
      begin
         s_d.dout[i] = s_d.warn && (s_q.dout_fn[i*8 +: 8] == DOUT_FAN_WARN);
      end

      // fan policy
      case (s_q.ctrl[CTRL_FAN_POL +: 2])
         FAN_DURING_RUN:
         begin
            // overheat forces fan regardless of run
            s_d.fan = drv_in.power_ok && (drv_in.run_cmd || hot);
         end
         FAN_ALWAYS:
         begin
            s_d.fan = drv_in.power_ok;
         end
         FAN_TEMP_CTRL:
         begin
            s_d.fan = drv_in.power_ok && drv_in.run_cmd && hot;
         end
         default:
         begin
            // unused code behaves as always-run, the safe side
            s_d.fan = drv_in.power_ok;
         end
      endcase

      // restart on release of the block input
      s_d.blk_in = blk_now;
      if (s_q.blk_in && !blk_now && drv_in.run_cmd && s_q.trip == 3'h0)
      begin
         s_d.accel = s_q.ctrl[CTRL_RESTART +: 2] == RESTART_ACCEL;
         s_d.search = s_q.ctrl[CTRL_RESTART +: 2] == RESTART_SEARCH;
      end

      // register writes; one cycle ack, unmapped addresses ignored
      if (wr)
      begin
         case (wb_req.adr)
            OFS_CTRL:
            begin
               wmrg = merge(32'(s_q.ctrl), wb_req.dat, wb_req.sel);
               s_d.ctrl = wmrg[CTRL_W-1:0];
            end
            OFS_OVS_LVL:
            begin
               wmrg = merge(32'(s_q.ovs_lvl), wb_req.dat, wb_req.sel);
               s_d.ovs_lvl = wmrg[15:0];
            end
            OFS_OVS_TIME:
            begin
               wmrg = merge(32'(s_q.ovs_time), wb_req.dat, wb_req.sel);
               s_d.ovs_time = wmrg[15:0];
            end
            OFS_DEV_HZ:
            begin
               wmrg = merge(32'(s_q.dev_hz), wb_req.dat, wb_req.sel);
               s_d.dev_hz = wmrg[15:0];
            end
            OFS_DEV_RPM:
            begin
               wmrg = merge(32'(s_q.dev_rpm), wb_req.dat, wb_req.sel);
               s_d.dev_rpm = wmrg[15:0];
            end
            OFS_DEV_TIME:
            begin
               wmrg = merge(32'(s_q.dev_time), wb_req.dat, wb_req.sel);
               s_d.dev_time = wmrg[15:0];
            end
            OFS_TEMP_THR:
            begin
               wmrg = merge(32'(s_q.temp_thr), wb_req.dat, wb_req.sel);
               s_d.temp_thr = wmrg[7:0];
            end
            OFS_DOUT_FN:
            begin
               wmrg = merge(32'(s_q.dout_fn), wb_req.dat, wb_req.sel);
               s_d.dout_fn = wmrg[23:0];
            end
            OFS_IRQ_ST:
            begin
               wmrg = wb_req.dat & {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                                    {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
               s_d.irq_st = s_q.irq_st & ~wmrg[IRQ_W-1:0];
            end
            OFS_IRQ_MASK:
            begin
               wmrg = merge(32'(s_q.irq_mask), wb_req.dat, wb_req.sel);
               s_d.irq_mask = wmrg[IRQ_W-1:0];
            end
            OFS_TRIP_CLR:
            begin
               wmrg = wb_req.dat & {24'h0, {8{wb_req.sel[0]}}};
               s_d.trip = s_q.trip & ~wmrg[2:0];
            end
            OFS_DIN_FN:
            begin
               s_d.din_fn = merge(s_q.din_fn, wb_req.dat, wb_req.sel);
            end
            default:
            begin
               s_d.ctrl = s_q.ctrl;
            end
         endcase
      end

      // event vector built here so no process reads another's output back
      ev = {s_d.accel || s_d.search, blk_now && !s_q.blk_in, s_d.warn && !s_q.warn,
            trip_set & ~s_q.trip};
      // hardware sets win over software clears
      s_d.trip = s_d.trip | trip_set;
      s_d.irq_st = s_d.irq_st | ev;
      // any latched trip or block input stops the inverter
      s_d.block = (s_d.trip != 3'h0) || blk_now;

      // read data, captured with the ack
      case (wb_req.adr)
         OFS_CTRL: s_d.rdat = 32'(s_q.ctrl);
         OFS_OVS_LVL: s_d.rdat = 32'(s_q.ovs_lvl);
         OFS_OVS_TIME: s_d.rdat = 32'(s_q.ovs_time);
         OFS_DEV_HZ: s_d.rdat = 32'(s_q.dev_hz);
         OFS_DEV_RPM: s_d.rdat = 32'(s_q.dev_rpm);
         OFS_DEV_TIME: s_d.rdat = 32'(s_q.dev_time);
         OFS_TEMP_THR: s_d.rdat = 32'(s_q.temp_thr);
         OFS_DOUT_FN: s_d.rdat = 32'(s_q.dout_fn);
         OFS_STATUS: s_d.rdat = status;
         OFS_IRQ_ST: s_d.rdat = 32'(s_q.irq_st);
         OFS_IRQ_MASK: s_d.rdat = 32'(s_q.irq_mask);
         OFS_DIN_FN: s_d.rdat = s_q.din_fn;
         default: s_d.rdat = 32'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_q <= '0;
         s_q.ctrl <= RST_CTRL;
         s_q.ovs_lvl <= RST_OVS_LVL;
         s_q.ovs_time <= RST_OVS_TIME;
         s_q.dev_hz <= RST_DEV_HZ;
         s_q.dev_rpm <= RST_DEV_RPM;
         s_q.dev_time <= RST_DEV_TIME;
         s_q.temp_thr <= RST_TEMP_THR;
         s_q.dout_fn <= RST_DOUT_FN;
         s_q.din_fn <= RST_DIN_FN;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign wb_dat_o = s_q.rdat;
   assign wb_ack_o = s_q.ack;
   assign output_block = s_q.block;
   assign fan_on = s_q.fan;
   assign dout = s_q.dout;
   assign accel_restart = s_q.accel;
   assign speed_search = s_q.search;
   // level interrupt from unmasked sticky events
   assign irq = |(s_q.irq_st & s_q.irq_mask);

endmodule : drive_speed_fan_protection

`default_nettype wire

// File: test/drive_speed_fan_protection_props.sv
// Purpose: port checks of the protection supervisor
// Assumes: one clock domain, settings invisible from here
// Notes: checks are relations between ports over time
`timescale 1ns/1ps
`default_nettype none
module prot_props
#(
   parameter int TICK_CYC = 10 // same time base as the design
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire drive_prot_pkg::wb_req_s wb_req,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire drive_prot_pkg::drive_in_s drv_in,
   input wire drive_prot_pkg::speed_in_s spd_in,
   input wire logic output_block,
   input wire logic fan_on,
   input wire logic [2:0] dout,
   input wire logic accel_restart,
   input wire logic speed_search,
   input wire logic irq
);
   import drive_prot_pkg::*;
   // ---------
   // sequences
   // ---------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   // request not yet answered
   sequence take_seq;
      wb_req.cyc && wb_req.stb && !wb_ack_o;
   endsequence
   // answer lasting one cycle only
   sequence pulse_seq;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   // any input terminal let go with run on, output free again
   sequence release_seq;
      (($past(drv_in.din, 2) & ~$past(drv_in.din)) != 8'h0) && $past(drv_in.run_cmd) && !output_block;
   endsequence
   // ----------
   // assertions
   // ----------
   ack_latency_a: assert property (take_seq |=> pulse_seq)
      else $error("bus answer not one cycle after request");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_req.cyc && wb_req.stb && !wb_ack_o))
      else $error("bus answer without request");
   dead_read_a: assert property (wb_ack_o && !wb_req.we
      && (wb_req.adr == OFS_TRIP_CLR || wb_req.adr[7:2] > 6'h0c) |-> wb_dat_o == 32'h0)
      else $error("dead place read not zero");
   restart_excl_a: assert property (!(accel_restart && speed_search))
      else $error("both restart kinds at once");
   accel_pulse_a: assert property (accel_restart |=> !accel_restart)
      else $error("accel restart longer than one cycle");
   search_pulse_a: assert property (speed_search |=> !speed_search)
      else $error("speed search longer than one cycle");
   restart_cause_a: assert property ((accel_restart || speed_search) |-> release_seq)
      else $error("restart without terminal release");
   warn_cause_a: assert property ((dout != 3'h0) |-> $past(drv_in.main_fan_err || drv_in.aux_fan_err))
      else $error("fan warning without fan error");
endmodule : prot_props
`default_nettype wire

// File: test/motor_fan_model.sv
// Purpose: motor and cooling fans beside the supervisor
// Assumes: bench sets wanted speed and broken fans
// Notes: a blocked motor coasts, seen here as zero speed
`timescale 1ns/1ps
`default_nettype none
module motor_fan_model
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic output_block,
   input wire logic fan_on,
   input wire logic [15:0] speed_set,
   input wire logic [1:0] fan_broken,
   output var logic [15:0] speed_pct,
   output var logic [1:0] fan_err
);
   // speed sensor and fan health
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         speed_pct <= 16'h0;
         fan_err <= 2'h0;
      end
      else
      begin
         // no torque while blocked
         speed_pct <= output_block ? 16'h0 : speed_set;
         // a stopped fan cannot be seen failing
         fan_err <= fan_on ? fan_broken : 2'h0;
      end
   end
endmodule : motor_fan_model
`default_nettype wire

// File: test/drive_speed_fan_protection_tb_top.sv
// Purpose: self-checking bench of the protection supervisor
// Assumes: ten cycles per tick
// Notes: expected notes queue up, a matcher takes them in order
`timescale 1ns/1ps
`default_nettype none
module drive_speed_fan_protection_tb_top;
   import drive_prot_pkg::*;
   localparam int TICK_CYC = 10; // short time base
   typedef struct {string nm; logic [31:0] m; logic [31:0] v;} note_s;
   localparam logic [7:0] RA [7] = '{OFS_CTRL, OFS_OVS_LVL, OFS_DEV_RPM, OFS_DOUT_FN, OFS_DIN_FN, OFS_TRIP_CLR, 8'h40};
   localparam logic [31:0] RV [7] = '{32'h1000, 32'h4b0, 32'h258, 32'he18, 32'h9cba5421, 32'h0, 32'h0};
   // policy, run, hot, power, fan
   localparam logic [5:0] FT [8] = '{6'h0b, 6'h02, 6'h07, 6'h13, 6'h10, 6'h2a, 6'h2f, 6'h33};
   localparam logic [7:0] MD [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h18, 8'h20};
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   wb_req_s wb_req = '0;
   drive_in_s cmd = '0; // bench half of drive inputs
   logic [15:0] spd_set = 16'h0;
   logic [15:0] dev_hz = 16'h0;
   logic [15:0] dev_rpm = 16'h0;
   logic [1:0] brk = 2'h0;
   logic [15:0] spd;
   logic [1:0] ferr;
   drive_in_s drv_w;
   speed_in_s spd_w;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, output_block, fan_on, accel_restart, speed_search, irq;
   logic [2:0] dout;
   logic [7:0] outv;
   logic snap = 1'b0; // toggles once per snapshot
   logic snap_seen = 1'b0;
   note_s nq[$];
   int n_errors = 0;
   int n_tests = 0;
   int seed = 32'h8372;
   assign drv_w = {cmd.power_ok, cmd.run_cmd, cmd.heat_temp, ferr[0], ferr[1], cmd.din};
   assign spd_w = {spd, dev_hz, dev_rpm};
   assign outv = {irq, accel_restart, speed_search, output_block, fan_on, dout};
   always #2.5 core_clk = ~core_clk;
   drive_speed_fan_protection #(.TICK_CYC(TICK_CYC)) i_drive_speed_fan_protection
   (
      .core_clk(core_clk), .rstn(rstn), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .drv_in(drv_w), .spd_in(spd_w), .output_block(output_block), .fan_on(fan_on), .dout(dout),
      .accel_restart(accel_restart), .speed_search(speed_search), .irq(irq)
   );
   motor_fan_model i_motor_fan_model
   (
      .core_clk(core_clk), .rstn(rstn), .output_block(output_block), .fan_on(fan_on),
      .speed_set(spd_set), .fan_broken(brk), .speed_pct(spd), .fan_err(ferr)
   );
   // -----
   // tasks
   // -----
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic results();
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic idle(int n);
      repeat (n) @(posedge core_clk);
   endtask : idle
   // one classic cycle, held until ack is seen
   task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1)
         n_errors++;
      wb_req <= '0;
   endtask : wb
   task automatic wr(logic [7:0] a, logic [31:0] d);
      wb(1'b1, a, d);
   endtask : wr
   task automatic rd(logic [7:0] a, logic [31:0] e);
      nq.push_back('{$sformatf("reg %h", a), 32'hffffffff, e});
      wb(1'b0, a, 32'h0);
   endtask : rd
   // snapshot of outputs in the next cycle
   task automatic look(string nm, logic [7:0] m, logic [7:0] e);
      nq.push_back('{nm, {24'h0, m}, {24'h0, e & m}});
      snap <= ~snap;
      @(posedge core_clk);
   endtask : look
   // matcher: oldest note against read data or snapshot
   always @(posedge core_clk)
   begin
      note_s nt;
      if ((wb_ack_o === 1'b1 && !wb_req.we) || snap != snap_seen)
      begin
         nt = nq.pop_front();
         check(nt.nm, (snap != snap_seen ? {24'h0, outv} : wb_dat_o) & nt.m, nt.v);
      end
      snap_seen = snap;
   end
   // watchdog, far beyond the some 900 cycles needed
   initial
   begin
      idle(8000);
      n_errors++;
      results();
   end
   // ---------
   // scenarios
   // ---------
   initial
   begin
      logic [5:0] f;
      logic [7:0] e;
      idle(5);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd(RA[i], RV[i]);
      for (int i = 0; i < 8; i++)
      begin
         f = FT[i];
         wr(OFS_CTRL, {22'h0, f[5:4], 8'h0});
         cmd.run_cmd <= f[3];
         cmd.heat_temp <= f[2] ? 8'h3c : 8'($unsigned($random(seed)) % 60);
         cmd.power_ok <= f[1];
         idle(3);
         look("fan", 8'h08, {4'h0, f[0], 3'h0});
      end
      for (int i = 0; i < 6; i++)
      begin
         wr(OFS_CTRL, {24'h0, MD[i]});
         spd_set <= 16'h04b1;
         idle(30);
         e = (i == 1 || i == 2 || i == 4) ? 8'h10 : 8'h00;
         look("ovs gate", 8'h10, e);
         spd_set <= 16'($unsigned($random(seed)) % 1201);
         wr(OFS_TRIP_CLR, 32'h7);
      end
      wr(OFS_OVS_TIME, 32'h3);
      wr(OFS_CTRL, 32'h3);
      spd_set <= 16'h04b1;
      idle(15);
      look("ovs early", 8'h10, 8'h00);
      idle(20);
      look("ovs late", 8'h10, 8'h10);
      spd_set <= 16'h04b0;
      wr(OFS_TRIP_CLR, 32'h7);
      wr(OFS_DEV_TIME, 32'h1);
      dev_hz <= 16'h0bb8;
      dev_rpm <= 16'h0258;
      idle(150);
      look("dev off", 8'h10, 8'h00);
      wr(OFS_CTRL, 32'hc4);
      idle(150);
      look("dev rpm edge", 8'h10, 8'h00);
      dev_rpm <= 16'h0259;
      idle(80);
      look("dev early", 8'h10, 8'h00);
      idle(30);
      look("dev late", 8'h10, 8'h10);
      dev_rpm <= 16'h0;
      dev_hz <= 16'h0;
      wr(OFS_TRIP_CLR, 32'h7);
      // main and aux, warning then trip
      wr(OFS_DOUT_FN, 32'h080008);
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_CTRL, i[1] ? 32'h0100 : 32'h0d00);
         brk <= i[0] ? 2'h2 : 2'h1;
         idle(4);
         look("fan fault", i[1] ? 8'h10 : 8'h17, i[1] ? 8'h10 : 8'h05);
         brk <= 2'h0;
         idle(4);
         wr(OFS_TRIP_CLR, 32'h7);
      end
      // release with each restart kind, interrupt on restart only
      wr(OFS_IRQ_ST, 32'h3f);
      wr(OFS_IRQ_MASK, 32'h20);
      cmd.run_cmd <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         wr(OFS_CTRL, i << 12);
         cmd.din[2] <= 1'b1;
         idle(3);
         look("block in", 8'h10, 8'h10);
         cmd.din[2] <= 1'b0;
         idle(1);
         e = (i == 1) ? 8'h40 : (i == 2) ? 8'h20 : 8'h00;
         look("restart", 8'h70, e);
         look("irq", 8'h80, e != 8'h0 ? 8'h80 : 8'h00);
         wr(OFS_IRQ_ST, 32'h3f);
         look("irq clr", 8'h80, 8'h00);
      end
      rd(OFS_IRQ_MASK, 32'h20);
      rd(OFS_STATUS, 32'h40);
      idle(2);
      results();
   end
endmodule : drive_speed_fan_protection_tb_top
bind drive_speed_fan_protection prot_props #(.TICK_CYC(TICK_CYC)) i_prot_props
(
   .core_clk(core_clk), .rstn(rstn), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .drv_in(drv_in), .spd_in(spd_in), .output_block(output_block), .fan_on(fan_on), .dout(dout),
   .accel_restart(accel_restart), .speed_search(speed_search), .irq(irq)
);
`default_nettype wire
